// *** common/odcd_pkg.sv ***
// Package with command codes, field positions, reset values and timing constants of the command decoder
package odcd_pkg;

  // Double-byte opcodes
  localparam logic [7:0] OP_CONTRAST  = 8'h81;
  localparam logic [7:0] OP_MUX       = 8'ha8;
  localparam logic [7:0] OP_DCDC      = 8'had;
  localparam logic [7:0] OP_ROW       = 8'hb0;
  localparam logic [7:0] OP_OFFSET    = 8'hd3;
  localparam logic [7:0] OP_CLKDIV    = 8'hd5;
  localparam logic [7:0] OP_PERIOD    = 8'hd9;
  localparam logic [7:0] OP_PADS      = 8'hda;
  localparam logic [7:0] OP_DESELECT  = 8'hdb;
  // Single-byte opcodes
  localparam logic [7:0] OP_RMW_START = 8'he0;
  localparam logic [7:0] OP_RMW_END   = 8'hee;
  localparam logic [7:0] OP_NOP       = 8'he3;

  // Reset values
  localparam logic [6:0] RST_COLUMN    = 7'h00;
  localparam logic [5:0] RST_START     = 6'h00;
  localparam logic [7:0] RST_CONTRAST  = 8'h80;
  localparam logic [5:0] RST_MUX       = 6'h3f;
  localparam logic [7:0] RST_DCDC      = 8'h81;
  localparam logic [5:0] RST_ROW       = 6'h00;
  localparam logic [5:0] RST_OFFSET    = 6'h00;
  localparam logic [7:0] RST_CLKDIV    = 8'h50;
  localparam logic [7:0] RST_PERIOD    = 8'h22;
  localparam logic [7:0] RST_PADS      = 8'h12;
  localparam logic [7:0] RST_DESELECT  = 8'h35;
  localparam logic [3:0] RST_DISCHARGE = 4'h0;

  // Field positions
  localparam int SEL_BIT     = 0;   // Selector bit of single-byte flag commands
  localparam int SCAN_BIT    = 3;   // Scan direction bit of 1100xxxx
  localparam int PAD_BIT     = 4;   // Pad order bit of the pad parameter
  localparam int STAT_BUSY   = 7;   // Busy in status byte
  localparam int STAT_OFF    = 6;   // Inverted on state in status byte

  // Timing: busy time after a command taken into the internal pipeline
  localparam int CLK_MHZ     = 50;
  localparam int BUSY_NS     = 100;
  localparam int BUSY_CYC_I  = (BUSY_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] BUSY_CYC = 4'(BUSY_CYC_I < 1 ? 1 : BUSY_CYC_I);

endpackage

// *** hdl/odcd_fifo.sv ***
`timescale 1ns/10ps
// Synchronous valid/ready FIFO buffering host bytes ahead of the decoder
module odcd_fifo #(
  parameter int WIDTH = 9,                        // Word width
  parameter int DEPTH = 16                        // Word count, power of two
) (
  input  wire logic             clock,            // System clock
  input  wire logic             resetn,           // Synchronous reset, active low
  input  wire logic [WIDTH-1:0] in_data,          // Word to store
  input  wire logic             in_valid,         // Word offered
  output logic                  in_ready,         // Room for a word
  output logic      [WIDTH-1:0] out_data,         // Oldest word
  output logic                  out_valid,        // Oldest word present
  input  wire logic             out_ready         // Drain accepts word
);
  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("odcd_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];                // Storage
  logic [AW:0]      wr_q;                         // Write pointer with wrap bit
  logic [AW:0]      rd_q;                         // Read pointer with wrap bit
  logic             push;                         // Word enters
  logic             pop;                          // Word leaves

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  // Full when pointers differ only in the wrap bit
  assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem_q[rd_q[AW-1:0]];

  ////////////////////////////////////////////////////////////////////////
  // Storage write
  always_ff @(posedge clock)
  begin
    if (push)
      mem_q[wr_q[AW-1:0]] <= in_data;
  end

  // Pointers
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
    end
  end
endmodule

// *** hdl/odcd_decoder.sv ***
`timescale 1ns/10ps
// Command decoder: host byte port, settings, column and row addressing, RAM, status and data reads
module odcd_decoder
  import odcd_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,                  // Depth of the host byte buffer
  parameter int COLS       = 128,                 // Column addresses (7 bits)
  parameter int ROWS       = 64                   // Row addresses (6 bits)
) (
  input  wire logic       clock,                  // 50 MHz system clock
  input  wire logic       resetn,                 // Synchronous reset, active low
  input  wire logic       wr_strobe,              // Host write strobe, pin, high for one write
  input  wire logic       rd_strobe,              // Host read strobe, pin, high for one read
  input  wire logic       command_data_select,    // Pin: 0 command/status, 1 display data
  input  wire logic [7:0] host_wdata,             // Pin: byte written by host
  input  wire logic       serial_mode,            // Pin: serial port selected, reads disabled
  output logic      [7:0] host_rdata,             // Byte returned for a read
  output logic            host_rdata_oe,          // Drive enable of data pins during read
  output logic      [6:0] column_address,         // Column address counter
  output logic      [5:0] row_address,            // Row address
  output logic      [5:0] start_line,             // Line shown on first common output
  output logic      [7:0] contrast,               // Contrast, 256 steps
  output logic            segment_remap,          // 0 right, 1 left rotation
  output logic            entire_on,              // Force all pixels on
  output logic            inverse,                // Inverted pixel polarity
  output logic      [5:0] mux_ratio,              // Multiplex ratio minus one
  output logic      [2:0] boost_freq,             // DC-DC switch frequency field
  output logic            dcdc_on,                // DC-DC converter enable
  output logic            display_on,             // Panel on
  output logic            scan_down,              // Common scan direction
  output logic      [5:0] offset_common_index,    // Display offset
  output logic      [3:0] osc_freq,               // Oscillator frequency select
  output logic      [3:0] display_clock_div,      // Display clock divide minus one
  output logic      [3:0] discharge_period,       // Discharge period in display clocks
  output logic      [3:0] precharge_period,       // Precharge period in display clocks
  output logic            pad_alternative,        // Common pad order alternative
  output logic      [7:0] deselect_level,         // Common deselect level code
  output logic      [3:0] segment_discharge_level,// Segment discharge level select
  output logic            rmw_active,             // Read-modify-write mode active
  output logic            busy                    // Busy, bytes rejected
);

  // Port widths fix the geometry
  initial
  begin
    if (COLS != 128 || ROWS != 64 || FIFO_DEPTH < 2)
      $error("odcd_decoder: unsupported geometry");
  end

  typedef enum logic [1:0] {ODCD_OPCODE, ODCD_PARAM} odcd_phase_e;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: two flops, only the second is read
  // A slow strobe edge is thus seen once
  logic [11:0] sync1_q;                           // First stage
  logic [11:0] sync2_q;                           // Second stage
  logic        wr_last_q;                         // Previous write strobe
  logic        rd_last_q;                         // Previous read strobe

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      sync1_q   <= '0;
      sync2_q   <= '0;
      wr_last_q <= 1'b0;
      rd_last_q <= 1'b0;
    end
    else
    begin
      sync1_q   <= {serial_mode, rd_strobe, wr_strobe, command_data_select, host_wdata};
      sync2_q   <= sync1_q;
      wr_last_q <= sync2_q[9];
      rd_last_q <= sync2_q[10];
    end
  end

  // Edge flops reset low, the strobes' idle level
  logic wr_event;                                 // Rising edge of write strobe
  logic rd_event;                                 // Rising edge of read strobe
  assign wr_event = sync2_q[9] && !wr_last_q;
  assign rd_event = sync2_q[10] && !rd_last_q;

  ////////////////////////////////////////////////////////////////////////
  // Host byte buffer; a byte arriving with the buffer full is dropped,
  // as the host is obliged to watch busy
  logic [8:0] f_out;                              // Select bit and byte
  logic       f_valid;                            // Byte waiting
  logic       f_in_ready;                         // Room in buffer
  logic       f_pop;                              // Decoder takes byte
  logic       busy_q;                             // Busy flag

  // Bytes seen while busy never enter
  // and are lost, not half-decoded
  odcd_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .resetn    (resetn),
    .in_data   (sync2_q[8:0]),
    .in_valid  (wr_event && !busy_q),
    .in_ready  (f_in_ready),
    .out_data  (f_out),
    .out_valid (f_valid),
    .out_ready (f_pop)
  );

  ////////////////////////////////////////////////////////////////////////
  // Busy: held a few cycles after each taken command, and while buffer is full
  logic [3:0] busy_cnt_q;                         // Busy countdown
  odcd_phase_e phase_q;                           // Opcode or parameter expected
  logic [7:0] pend_q;                             // Pending double-byte opcode

  assign f_pop = f_valid && (busy_cnt_q == '0);

  // Busy countdown restarts on every decoded byte
  // It models the settle time of a setting
  // and holds the next byte back
  always_ff @(posedge clock)
  begin
    if (!resetn)
      busy_cnt_q <= BUSY_CYC;                     // Busy during and just after reset
    else if (f_pop)
      busy_cnt_q <= BUSY_CYC;
    else if (busy_cnt_q != '0)
      busy_cnt_q <= busy_cnt_q - 4'h1;
  end

  // Busy flag seen by host; reflects countdown, byte being taken and full buffer
  // Registered, so pin and status bit agree
  always_ff @(posedge clock)
  begin
    if (!resetn)
      busy_q <= 1'b1;
    else
      busy_q <= (busy_cnt_q > 4'h1) || f_pop || !f_in_ready;
  end
  assign busy = busy_q;

  // Buffer head is the byte being decoded
  logic       is_cmd;                             // Byte is a command-phase byte
  logic [7:0] byte_v;                             // Byte being decoded
  assign is_cmd = f_pop && !f_out[8];
  assign byte_v = f_out[7:0];

  // True for opcodes that take a parameter byte
  function automatic logic is_double(input logic [7:0] b);
    return b inside {OP_CONTRAST, OP_MUX, OP_DCDC, OP_ROW, OP_OFFSET,
                     OP_CLKDIV, OP_PERIOD, OP_PADS, OP_DESELECT};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Opcode/parameter phase tracking
  // Data bytes leave the phase alone,
  // so data may sit inside a pair
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      phase_q <= ODCD_OPCODE;
      pend_q  <= OP_NOP;
    end
    else if (is_cmd)
    begin
      case (phase_q)
        ODCD_OPCODE:
        begin
          if (is_double(byte_v))
          begin
            phase_q <= ODCD_PARAM;
            pend_q  <= byte_v;
          end
        end
        ODCD_PARAM:
          phase_q <= ODCD_OPCODE;
        default:
          phase_q <= ODCD_OPCODE;
      endcase
    end
  end


  // Command byte qualified by phase
  logic single_ok;                                // Single-byte opcode in hand
  logic param_ok;                                 // Parameter byte in hand
  assign single_ok = is_cmd && (phase_q == ODCD_OPCODE);
  assign param_ok  = is_cmd && (phase_q == ODCD_PARAM);

  ////////////////////////////////////////////////////////////////////////
  // Single-byte settings; reserved codes fall through and change nothing
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      start_line              <= RST_START;
      segment_remap           <= 1'b0;
      entire_on               <= 1'b0;
      inverse                 <= 1'b0;
      display_on              <= 1'b0;
      scan_down               <= 1'b0;
      segment_discharge_level <= RST_DISCHARGE;
    end
    else if (single_ok)
    begin
      if (byte_v[7:6] == 2'b01)
        start_line <= byte_v[5:0];
      else if (byte_v[7:4] == 4'h3)
        segment_discharge_level <= byte_v[3:0];
      else if (byte_v[7:1] == 7'b1010000)
        segment_remap <= byte_v[SEL_BIT];
      else if (byte_v[7:1] == 7'b1010010)
        entire_on <= byte_v[SEL_BIT];
      else if (byte_v[7:1] == 7'b1010011)
        inverse <= byte_v[SEL_BIT];
      else if (byte_v[7:1] == 7'b1010111)
        display_on <= byte_v[SEL_BIT];
      else if (byte_v[7:4] == 4'hc)
        scan_down <= byte_v[SCAN_BIT];
      // No-operation code: nothing moves
      else if (byte_v == OP_NOP)
        scan_down <= scan_down;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Parameter settings of double-byte commands
  // Bits outside a field are dropped
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      contrast            <= RST_CONTRAST;
      mux_ratio           <= RST_MUX;
      {boost_freq, dcdc_on} <= RST_DCDC[3:0];
      row_address         <= RST_ROW;
      offset_common_index <= RST_OFFSET;
      {osc_freq, display_clock_div} <= RST_CLKDIV;
      {discharge_period, precharge_period} <= RST_PERIOD;
      pad_alternative     <= RST_PADS[PAD_BIT];
      deselect_level      <= RST_DESELECT;
    end
    else if (param_ok)
    begin
      case (pend_q)
        OP_CONTRAST: contrast <= byte_v;
        OP_MUX:      mux_ratio <= byte_v[5:0];
        OP_DCDC:     {boost_freq, dcdc_on} <= byte_v[3:0];
        OP_ROW:      row_address <= byte_v[5:0];
        OP_OFFSET:   offset_common_index <= byte_v[5:0];
        OP_CLKDIV:   {osc_freq, display_clock_div} <= byte_v;
        OP_PERIOD:   {discharge_period, precharge_period} <= byte_v;
        OP_PADS:     pad_alternative <= byte_v[PAD_BIT];
        OP_DESELECT: deselect_level <= byte_v;
        default:     contrast <= contrast;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Column counter and read-modify-write; NOP takes its own branch and holds the column
  // Commands win over data; the host waits
  // on busy, so both never meet in a cycle
  logic [6:0] rmw_save_q;                         // Column saved at mode start
  logic       data_wr;                            // Display data write taken
  logic       data_rd;                            // Display data read
  assign data_wr = f_pop && f_out[8];
  assign data_rd = rd_event && sync2_q[8] && !sync2_q[11];

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      column_address <= RST_COLUMN;
      rmw_active     <= 1'b0;
      rmw_save_q     <= RST_COLUMN;
    end
    else if (single_ok && byte_v[7:4] == 4'h0)
      column_address[3:0] <= byte_v[3:0];
    else if (single_ok && byte_v[7:3] == 5'b00010)
      column_address[6:4] <= byte_v[2:0];
    else if (single_ok && byte_v == OP_RMW_START)
    begin
      rmw_active <= 1'b1;
      rmw_save_q <= column_address;
    end
    else if (single_ok && byte_v == OP_RMW_END)
    begin
      rmw_active     <= 1'b0;
      if (rmw_active)
        column_address <= rmw_save_q;
    end
    else if (single_ok && byte_v == OP_NOP)
      column_address <= column_address;
    else if (data_wr)
      column_address <= column_address + 7'h1;
    else if (data_rd && !rmw_active)
      column_address <= column_address + 7'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Display RAM, one byte per row and column address
  // No reset: undefined until written
  logic [7:0] ram_q [ROWS*COLS];                  // Display data
  logic [7:0] ram_rd_q;                           // Read latch, gives the dummy read

  always_ff @(posedge clock)
  begin
    if (data_wr)
      ram_q[{row_address, column_address}] <= byte_v;
  end

  // Output latch updated after each read, so first read after set returns stale data
  // Costs a dummy read, keeps RAM a plain array
  always_ff @(posedge clock)
  begin
    if (!resetn)
      ram_rd_q <= 8'h00;
    else if (data_rd)
      ram_rd_q <= ram_q[{row_address, column_address}];
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port: status byte or latched RAM byte; serial port cannot read
  // Status is built at the strobe edge,
  // so its busy bit can be stale when sampled
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      host_rdata    <= 8'h00;
      host_rdata_oe <= 1'b0;
    end
    else
    begin
      host_rdata_oe <= sync2_q[10] && !sync2_q[11];
      if (rd_event && !sync2_q[8])
      begin
        host_rdata            <= 8'h00;
        host_rdata[STAT_BUSY] <= busy_q;
        host_rdata[STAT_OFF]  <= !display_on;
      end
      else if (rd_event)
        host_rdata <= ram_rd_q;
    end
  end

endmodule

// *** test/odcd_decoder_sva.sv ***
// Port assertions for the command decoder
`timescale 1ns/10ps
module odcd_decoder_sva (
  input wire logic       clock,               // Clock
  input wire logic       resetn,              // Reset, active low
  input wire logic       wr_strobe,           // Write strobe
  input wire logic       rd_strobe,           // Read strobe
  input wire logic       command_data_select, // Byte kind
  input wire logic       serial_mode,         // Serial port
  input wire logic [7:0] host_rdata,          // Read byte
  input wire logic       host_rdata_oe,       // Read drive
  input wire logic [6:0] column_address,      // Column
  input wire logic [5:0] row_address,         // Row
  input wire logic [7:0] contrast,            // Contrast
  input wire logic [5:0] mux_ratio,           // Multiplex
  input wire logic       segment_remap,       // Remap
  input wire logic       entire_on,           // All on
  input wire logic       inverse,             // Inverse
  input wire logic       display_on,          // Panel on
  input wire logic       scan_down,           // Scan
  input wire logic       rmw_active,          // Read-modify-write
  input wire logic       busy                 // Busy
);
  default clocking dcb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Bus drive only follows a read strobe, never in serial mode
  a_oe_after_read: assert property (host_rdata_oe |-> $past(rd_strobe, 2) || $past(rd_strobe, 3) || $past(rd_strobe, 4))
    else $error("read drive without read strobe");
  a_serial_no_read: assert property (serial_mode [*4] |-> !host_rdata_oe)
    else $error("read drive in serial mode");
  // Status byte carries inverted panel state, low bits zero
  a_status_form: assert property ($rose(host_rdata_oe) && !command_data_select |=> host_rdata[6:0] == {!display_on, 6'h00})
    else $error("status byte malformed");
  a_busy_short: assert property ($rose(busy) |-> ##[1:8] !busy)
    else $error("busy held too long");
  // Settings move only as a result of a taken byte; the column also moves on a read
  a_quiet_stable: assert property (!wr_strobe [*8] |-> $stable({contrast, mux_ratio, row_address, rmw_active}))
    else $error("setting moved without write");
  a_flags_busy: assert property ($changed({display_on, scan_down, segment_remap, entire_on, inverse}) |-> busy)
    else $error("flag changed outside command");
  a_pair_busy: assert property ($changed({contrast, mux_ratio, row_address}) |-> busy)
    else $error("pair value changed outside command");
  a_col_quiet: assert property ((!wr_strobe && !rd_strobe) [*8] |-> $stable(column_address))
    else $error("column moved without access");
  // Reads in read-modify-write mode must not move the column
  a_rmw_hold: assert property ((rmw_active && !wr_strobe) [*8] |-> $stable(column_address))
    else $error("column moved by read in rmw mode");
endmodule
bind odcd_decoder odcd_decoder_sva u_sva (.*);

// *** test/odcd_host_model.sv ***
// Host processor model on the decoder's byte port
`timescale 1ns/10ps
module odcd_host_model (
  input  wire logic       clock,               // Clock
  input  wire logic       busy,                // Device busy
  input  wire logic [7:0] host_rdata,          // Read byte
  output logic            wr_strobe,           // Write strobe
  output logic            rd_strobe,           // Read strobe
  output logic            command_data_select, // Byte kind
  output logic      [7:0] host_wdata           // Write byte
);
  int n; // Wait bound
  initial
  begin
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    command_data_select = 1'b0;
    host_wdata = 8'h00;
  end
  // Wait busy low; bounded so a stuck device cannot hang the host
  task automatic idle();
    n = 0;
    while (busy !== 1'b0 && n < 40)
    begin
      @(negedge clock);
      n++;
    end
    if (n >= 40)
    begin
      odcd_decoder_tb_top.num_errors++;
      $display("[FAIL] busy expected 0 seen %b", busy);
    end
  endtask
  // Write a byte; impolite skips the busy wait on purpose
  task automatic wr(input logic cds, input logic [7:0] d, input logic polite);
    if (polite)
      idle();
    @(negedge clock);
    command_data_select = cds;
    host_wdata = d;
    wr_strobe = 1'b1;
    repeat (4) @(negedge clock);
    wr_strobe = 1'b0;
    repeat (3) @(negedge clock);
    host_wdata = ~d; // Released bus shows no stale byte
    if (polite)
      idle();
  endtask
  // Read a byte; the caller does the dummy read after a column set
  task automatic rd(input logic cds, output logic [7:0] q);
    idle();
    @(negedge clock);
    command_data_select = cds;
    rd_strobe = 1'b1;
    repeat (5) @(negedge clock);
    q = host_rdata;
    rd_strobe = 1'b0;
    repeat (4) @(negedge clock);
  endtask
endmodule

// *** test/odcd_decoder_tb_top.sv ***
// Self-checking bench for the command decoder
`timescale 1ns/10ps
module odcd_decoder_tb_top;
  import odcd_pkg::*;
  logic       clock = 1'b0;                    // Clock
  logic       resetn, serial_mode;             // Reset, serial pin
  logic       wr_strobe, rd_strobe, command_data_select;
  logic [7:0] host_wdata, host_rdata, contrast, deselect_level, q;
  logic [6:0] column_address;                  // Column
  logic [5:0] row_address, start_line, mux_ratio, offset_common_index;
  logic [3:0] osc_freq, display_clock_div, discharge_period, precharge_period, segment_discharge_level;
  logic [2:0] boost_freq;                      // Switch frequency
  logic       host_rdata_oe, segment_remap, entire_on, inverse, dcdc_on, display_on;
  logic       scan_down, pad_alternative, rmw_active, busy;
  int         num_errors = 0;                  // Mismatches
  int         samples_checked = 0;             // Comparisons
  logic [7:0] sb[9] = '{8'h05, 8'h13, 8'h4a, 8'ha1, 8'ha5, 8'ha7, 8'haf, 8'hc8, 8'h3c};
  logic [7:0] cb[5] = '{8'ha0, 8'ha4, 8'ha6, 8'hae, 8'hc7};
  logic [7:0] op[9] = '{8'h81, 8'ha8, 8'had, 8'hb0, 8'hd3, 8'hd5, 8'hd9, 8'hda, 8'hdb};
  logic [7:0] pa[9] = '{8'haf, 8'h1f, 8'h8b, 8'hea, 8'hd0, 8'hf3, 8'h4e, 8'h02, 8'h7c};
  always #10 clock = ~clock;
  odcd_decoder u_dut (.*);
  odcd_host_model u_host (.*);
  ////////////////////////////////////////////////////////////////////////////////
  // Compare one byte
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic do_reset();
    resetn = 1'b0;
    repeat (5) @(negedge clock);
    resetn = 1'b1;
  endtask
  // Power-on values of every setting except segment_discharge_level
  task automatic t_reset_values();
    chk("contrast", RST_CONTRAST, contrast);
    chk("mux", 8'h3f, {2'h0, mux_ratio});
    chk("dcdc", 8'h81, {4'h8, boost_freq, dcdc_on});
    chk("clkdiv", 8'h50, {osc_freq, display_clock_div});
    chk("period", 8'h22, {discharge_period, precharge_period});
    chk("pads", 8'h12, {3'h0, pad_alternative, 4'h2});
    chk("deselect", 8'h35, deselect_level);
    chk("column", 8'h00, {1'b0, column_address});
    chk("start", 8'h00, {2'h0, start_line});
    chk("row", 8'h00, {2'h0, row_address});
    chk("offset", 8'h00, {2'h0, offset_common_index});
    chk("flags", 8'h00, {segment_remap, entire_on, inverse, display_on, scan_down, rmw_active, 2'h0});
  endtask
  // Single-byte commands set, then cleared with don't-care bits set
  task automatic t_single();
    foreach (sb[i]) u_host.wr(1'b0, sb[i], 1'b1);
    chk("column", 8'h35, {1'b0, column_address});
    chk("start", 8'h0a, {2'h0, start_line});
    chk("flags", 8'hf8, {segment_remap, entire_on, inverse, display_on, scan_down, 3'h0});
    chk("vsl", 8'h0c, {4'h0, segment_discharge_level});
    foreach (cb[i]) u_host.wr(1'b0, cb[i], 1'b1);
    chk("flags", 8'h00, {segment_remap, entire_on, inverse, display_on, scan_down, 3'h0});
  endtask
  // Each pair split by a data byte; parameters look like opcodes
  task automatic t_double();
    foreach (op[i])
    begin
      u_host.wr(1'b0, op[i], 1'b1);
      u_host.wr(1'b1, 8'h5a, 1'b1);
      u_host.wr(1'b0, pa[i], 1'b1);
    end
    chk("contrast", 8'haf, contrast);
    chk("on", 8'h00, {7'h0, display_on});
    chk("mux", 8'h1f, {2'h0, mux_ratio});
    chk("dcdc", 8'h8b, {4'h8, boost_freq, dcdc_on});
    chk("row", 8'h2a, {2'h0, row_address});
    chk("offset", 8'h10, {2'h0, offset_common_index});
    chk("clkdiv", 8'hf3, {osc_freq, display_clock_div});
    chk("period", 8'h4e, {discharge_period, precharge_period});
    chk("pads", 8'h02, {3'h0, pad_alternative, 4'h2});
    chk("deselect", 8'h7c, deselect_level);
    chk("column", 8'h3e, {1'b0, column_address});
    u_host.wr(1'b0, OP_NOP, 1'b1);
    chk("nop", 8'haf, contrast);
    chk("nop column", 8'h3e, {1'b0, column_address});
  endtask
  // RAM write and read back, then read-modify-write restores the column
  task automatic t_rmw();
    u_host.wr(1'b0, 8'h00, 1'b1);
    u_host.wr(1'b0, 8'h12, 1'b1);
    u_host.wr(1'b1, 8'h9c, 1'b1);
    u_host.wr(1'b0, 8'h00, 1'b1);
    u_host.wr(1'b0, 8'h12, 1'b1);
    u_host.rd(1'b1, q);
    u_host.rd(1'b1, q);
    chk("ram", 8'h9c, q);
    u_host.wr(1'b0, OP_RMW_START, 1'b1);
    u_host.rd(1'b1, q);
    chk("rmw read", 8'h22, {1'b0, column_address});
    u_host.wr(1'b1, 8'h11, 1'b1);
    chk("rmw write", 8'h23, {1'b0, column_address});
    chk("rmw on", 8'h01, {7'h0, rmw_active});
    u_host.wr(1'b0, OP_RMW_END, 1'b1);
    chk("rmw end", 8'h22, {1'b0, column_address});
  endtask
  // Status in both panel states, then serial mode blocks reads
  task automatic t_status();
    u_host.rd(1'b0, q);
    chk("status off", 8'h40, q);
    u_host.wr(1'b0, 8'haf, 1'b1);
    u_host.rd(1'b0, q);
    chk("status on", 8'h00, q);
    serial_mode = 1'b1;
    u_host.rd(1'b1, q);
    chk("serial column", 8'h22, {1'b0, column_address});
    serial_mode = 1'b0;
  endtask
  // Byte during post-reset busy is dropped; a later one is taken
  task automatic t_reject();
    do_reset();
    u_host.wr(1'b0, 8'haf, 1'b0);
    u_host.idle();
    chk("rejected", 8'h00, {7'h0, display_on});
    chk("reset contrast", RST_CONTRAST, contrast);
    u_host.wr(1'b0, 8'haf, 1'b1);
    chk("accepted", 8'h01, {7'h0, display_on});
  endtask
  task automatic end_of_test();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog: the run needs about 12 us
  initial
  begin
    #400000;
    num_errors++;
    $display("[FAIL] watchdog expected done seen hang");
    end_of_test();
  end
  initial
  begin
    serial_mode = 1'b0;
    do_reset();
    t_reset_values();
    t_single();
    t_double();
    t_rmw();
    t_status();
    t_reject();
    end_of_test();
  end
endmodule
